// ==== rtl/acq_ctrl.sv ====
// Converter acquisition control with APB registers and packing DMA
`timescale 1ns/1ps
`default_nettype none
module acq_ctrl #(
  parameter int CW = 16
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Converter
  input  wire logic        ext_clk,
  input  wire logic        dig_trig,
  input  wire logic        ext_trig,
  input  wire logic        conv_done,
  input  wire logic [15:0] conv_value,
  output logic             conv_start,
  output logic [3:0]       conv_chan,
  output logic             burst_run,
  output logic             burst_hold,
  // DMA to host memory
  output logic             dma_valid,
  output logic [31:0]      dma_data,
  input  wire logic        dma_ready,
  output logic             term_count
);
  logic [7:0]    func;
  logic [5:0]    ctl_mode;
  logic [15:0]   div1, div2, post_cnt;
  logic [CW-1:0] n_cnt, xfer_cnt, post_left;
  logic [3:0]    last_chan;
  logic          running, triggered, ready_n, half_full, stop_pend;
  logic [15:0]   result, low_half;
  logic [4:0]    base_cnt;
  logic [15:0]   c1, c2;
  logic          ext_q, ext_edge, tick, dq, eq, trig_hit;
  logic          wr, rd;
  logic [15:0]   sample;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;

  // Single write updates every mode bit
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      func <= acq_pkg::FUNC_RESET;
    end else if (wr && paddr == acq_pkg::ADDR_FUNC) begin
      func <= pwdata[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_mode  <= 6'h00;
      div1      <= 16'h0001;
      div2      <= 16'h0001;
      n_cnt     <= '0;
      post_cnt  <= 16'h0000;
      last_chan <= acq_pkg::CHAN_LAST_RST;
    end else if (wr) begin
      unique case (paddr)
        acq_pkg::ADDR_CTRL:  begin
          ctl_mode  <= {pwdata[acq_pkg::CTL_WIDE], pwdata[acq_pkg::CTL_SCAN],
                        pwdata[acq_pkg::CTL_EXT_CLK], 3'b000};
          last_chan <= pwdata[11:8];
        end
        acq_pkg::ADDR_DIV:   begin
          div1 <= pwdata[15:0];
          div2 <= pwdata[31:16];
        end
        acq_pkg::ADDR_COUNT: n_cnt <= pwdata[CW-1:0];
        acq_pkg::ADDR_POST:  post_cnt <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // External pacer clock edge; 4 MHz base tick
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_q    <= 1'b0;
      base_cnt <= 5'h00;
      dq       <= 1'b0;
      eq       <= 1'b0;
    end else begin
      ext_q    <= ext_clk;
      dq       <= dig_trig;
      eq       <= ext_trig;
      base_cnt <= (base_cnt == 5'(acq_pkg::BASE_DIV - 1)) ? 5'h00 : base_cnt + 5'h01;
    end
  end
  assign ext_edge = ext_clk && !ext_q;

  // Cascaded pacer dividers, halted when not running
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      c1   <= 16'h0001;
      c2   <= 16'h0001;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (!running) begin
        c1 <= div1;
        c2 <= div2;
      end else if (ctl_mode[acq_pkg::CTL_EXT_CLK] ? ext_edge
                   : (base_cnt == 5'h00)) begin
        if (c1 <= 16'h0001) begin
          c1 <= div1;
          if (c2 <= 16'h0001) begin
            c2   <= div2;
            tick <= 1'b1;
          end else begin
            c2 <= c2 - 16'h0001;
          end
        end else begin
          c1 <= c1 - 16'h0001;
        end
      end
    end
  end

  // Trigger edge with selectable polarity
  assign trig_hit = (func[acq_pkg::BIT_DPOL] ? (dig_trig && !dq) : (!dig_trig && dq))
                 || (func[acq_pkg::BIT_EPOL] ? (ext_trig && !eq) : (!ext_trig && eq));

  // Conversion start: soft trigger or pacer tick
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_start <= 1'b0;
      burst_run  <= 1'b0;
      burst_hold <= 1'b0;
    end else begin
      conv_start <= (wr && paddr == acq_pkg::ADDR_CTRL && pwdata[acq_pkg::CTL_SOFT_TRIG])
                 || (tick && running);
      burst_run  <= func[acq_pkg::BIT_BMODE] && func[acq_pkg::BIT_BSTART];
      burst_hold <= func[acq_pkg::BIT_BMODE] && func[acq_pkg::BIT_BSH];
    end
  end

  // Channel sequencing
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_chan <= 4'h0;
    end else if (!running) begin
      conv_chan <= 4'h0;
    end else if (conv_done && ctl_mode[acq_pkg::CTL_SCAN]) begin
      conv_chan <= (conv_chan == last_chan) ? 4'h0 : conv_chan + 4'h1;
    end
  end

  // Result formatting
  assign sample = ctl_mode[acq_pkg::CTL_WIDE] ? conv_value
                : {conv_value[11:0], conv_chan};

  // Polled result and ready flag, set beats clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      result  <= 16'h0000;
      ready_n <= 1'b1;
    end else if (conv_done) begin
      result  <= sample;
      ready_n <= 1'b0;
    end else if (rd && paddr == acq_pkg::ADDR_RESULT) begin
      ready_n <= 1'b1;
    end
  end

  // Paced run sequencing, packing and end conditions
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      running    <= 1'b0;
      triggered  <= 1'b0;
      xfer_cnt   <= '0;
      post_left  <= '0;
      half_full  <= 1'b0;
      low_half   <= 16'h0000;
      dma_valid  <= 1'b0;
      dma_data   <= 32'h0000_0000;
      term_count <= 1'b0;
      stop_pend  <= 1'b0;
    end else begin
      term_count <= 1'b0;
      if (dma_valid && dma_ready) begin
        dma_valid <= 1'b0;
      end
      if (wr && paddr == acq_pkg::ADDR_CTRL && pwdata[acq_pkg::CTL_DMA_GO]) begin
        running   <= 1'b1;
        triggered <= 1'b0;
        xfer_cnt  <= '0;
        half_full <= 1'b0;
        stop_pend <= 1'b0;
        post_left <= CW'(post_cnt);
      end else if (running) begin
        if (wr && paddr == acq_pkg::ADDR_CTRL && pwdata[acq_pkg::CTL_STOP]) begin
          running <= 1'b0;
        end
        if (func[acq_pkg::BIT_TSTART] && trig_hit
            && (func[acq_pkg::BIT_POST] || func[acq_pkg::BIT_ABOUT])) begin
          triggered <= 1'b1;
        end
        if (conv_done) begin
          xfer_cnt <= xfer_cnt + CW'(1);
          if (half_full) begin
            dma_data  <= {sample, low_half};
            dma_valid <= 1'b1;
          end else begin
            low_half <= sample;
          end
          half_full <= !half_full;
          if (triggered) begin
            post_left <= post_left - CW'(1);
            if (post_left <= CW'(1)) begin
              running    <= 1'b0;
              term_count <= 1'b1;
            end
          end
          if (!(func[acq_pkg::BIT_TSTART] && (func[acq_pkg::BIT_POST]
                || func[acq_pkg::BIT_ABOUT])) && xfer_cnt + CW'(1) >= n_cnt) begin
            running    <= 1'b0;
            term_count <= 1'b1;
          end
        end
      end
    end
  end

  // APB read path
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && paddr > acq_pkg::ADDR_XFER;
      if (rd) begin
        unique case (paddr)
          acq_pkg::ADDR_FUNC:   prdata <= {24'h000000, func};
          acq_pkg::ADDR_CTRL:   prdata <= {20'h00000, last_chan, 2'b00, ctl_mode};
          acq_pkg::ADDR_DIV:    prdata <= {div2, div1};
          acq_pkg::ADDR_COUNT:  prdata <= 32'(n_cnt);
          acq_pkg::ADDR_POST:   prdata <= {16'h0000, post_cnt};
          acq_pkg::ADDR_STATUS: prdata <= {29'h0, triggered, ready_n, running};
          acq_pkg::ADDR_RESULT: prdata <= {16'h0000, result};
          acq_pkg::ADDR_XFER:   prdata <= 32'(xfer_cnt);
          default:              prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/acq_pkg.sv ====
// Constants for the converter acquisition control block
// Functional notes
// - Function register bits: polarities, burst, modes, start
// - Burst start runs burst only when enabled
// - Post-trigger enable bit gates post-trigger mode
// - About-trigger enable bit gates about-trigger mode
// - Soft trigger; ready flag low when result valid
// - Narrow result: channel low nibble, value above
// - Wide result: whole word signed value
// - Rate is base divided by two cascaded dividers
// - Pacer clock from internal or external source
// - Paced run ends after N or stop
// - Auto-scan steps channels, else one channel
// - Two samples per word, earlier low
// - Trigger modes end after post-trigger countdown
// - Polarity bits: 0 falling, 1 rising edge
// - Sample-hold bit selects burst with hold
// - Stop disables trigger and halts both dividers
// - Running flag and transferred count readable
package acq_pkg;
  localparam logic [7:0] ADDR_FUNC     = 8'h00;
  localparam logic [7:0] ADDR_CTRL     = 8'h04;
  localparam logic [7:0] ADDR_DIV      = 8'h08;
  localparam logic [7:0] ADDR_COUNT    = 8'h0C;
  localparam logic [7:0] ADDR_POST     = 8'h10;
  localparam logic [7:0] ADDR_STATUS   = 8'h14;
  localparam logic [7:0] ADDR_RESULT   = 8'h18;
  localparam logic [7:0] ADDR_XFER     = 8'h1C;
  localparam int         BIT_DPOL      = 7;
  localparam int         BIT_EPOL      = 6;
  localparam int         BIT_BSH       = 5;
  localparam int         BIT_BMODE     = 4;
  localparam int         BIT_BSTART    = 3;
  localparam int         BIT_POST      = 2;
  localparam int         BIT_ABOUT     = 1;
  localparam int         BIT_TSTART    = 0;
  localparam int         CTL_DMA_GO    = 0;
  localparam int         CTL_STOP      = 1;
  localparam int         CTL_SOFT_TRIG = 2;
  localparam int         CTL_EXT_CLK   = 3;
  localparam int         CTL_SCAN      = 4;
  localparam int         CTL_WIDE      = 5;
  localparam logic [7:0] FUNC_RESET    = 8'h00;
  localparam logic [3:0] CHAN_LAST_RST = 4'hF;
  localparam int         BASE_HZ       = 4000000;
  localparam int         CLK_HZ        = 100000000;
  localparam int         BASE_DIV      = CLK_HZ / BASE_HZ;
endpackage

// ==== test/acq_ctrl_assertions.sv ====
// Port-level assertions for the acquisition control block
`timescale 1ns/1ps
`default_nettype none
module acq_ctrl_assertions #(
  parameter int CW = 16
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        arst_n,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Converter and transfer
  input wire logic        conv_start,
  input wire logic        conv_done,
  input wire logic        burst_run,
  input wire logic        burst_hold,
  input wire logic        dma_valid,
  input wire logic [31:0] dma_data,
  input wire logic        dma_ready,
  input wire logic        term_count
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic wr_acc;
  assign wr_acc = psel && penable && pready && pwrite;
  property p_burst;
    logic [2:0] v;
    (wr_acc && paddr == 8'h00, v = pwdata[5:3]) |-> ##2
      burst_run == (v[1] && v[0]) && burst_hold == (v[1] && v[2]);
  endproperty
  chk_apb_answer: assert property (
    psel && !penable |=> pready && penable) else $error("no answer to setup");
  chk_unmapped_err: assert property (
    pready && paddr > 8'h1C |-> pslverr) else $error("unmapped without error");
  chk_burst_bits: assert property (p_burst)
    else $error("burst outputs disagree with mode write");
  chk_soft_trig: assert property (
    wr_acc && paddr == 8'h04 && pwdata[2] |=> conv_start) else $error("no start");
  chk_start_pulse: assert property (
    conv_start |=> !conv_start) else $error("start longer than one cycle");
  chk_dma_hold: assert property (
    dma_valid && !dma_ready |=> dma_valid && $stable(dma_data)) else $error("word lost");
  chk_dma_cause: assert property (
    $rose(dma_valid) |-> $past(conv_done) || $past(conv_done, 2))
    else $error("word without conversion");
  chk_tc_pulse: assert property (
    term_count |=> !term_count) else $error("terminal count not a pulse");
  chk_stop_quiet: assert property (
    wr_acc && paddr == 8'h04 && pwdata[1] |-> ##2 !conv_start [*8])
    else $error("start after stop");
  cover property (conv_start && !psel);
  cover property (dma_valid && dma_ready);
  cover property (term_count);
endmodule
`default_nettype wire

// ==== test/acq_ctrl_tb.sv ====
// Self-checking bench for the acquisition control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module acq_ctrl_tb;
  logic        core_clk, arst_n, psel, penable, pwrite, pready, pslverr, ext_clk, e;
  logic        dig_trig, ext_trig, conv_done, conv_start, burst_run, burst_hold;
  logic        dma_valid, dma_ready, term_count;
  logic [7:0]  paddr;
  logic [15:0] conv_value;
  logic [3:0]  conv_chan;
  logic [31:0] pwdata, prdata, dma_data, q;
  logic [31:0] words[$];
  int          error_cnt, check_count, cyc, n_done, n_start, n_tc, b, t, gap, last;
  logic [7:0]  fv[10] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80,
                          8'h18, 8'h30};
  logic [7:0]  md[2] = '{8'hC5, 8'hC3};
  acq_ctrl #(.CW(16)) DUT (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_clk(ext_clk), .dig_trig(dig_trig),
    .ext_trig(ext_trig), .conv_done(conv_done), .conv_value(conv_value),
    .conv_start(conv_start), .conv_chan(conv_chan), .burst_run(burst_run),
    .burst_hold(burst_hold), .dma_valid(dma_valid), .dma_data(dma_data),
    .dma_ready(dma_ready), .term_count(term_count));
  conv_model #(.DLY(5)) u_conv (.core_clk(core_clk), .arst_n(arst_n),
    .conv_start(conv_start), .conv_chan(conv_chan), .conv_done(conv_done),
    .conv_value(conv_value));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Far side stalls one cycle in three
  always @(posedge core_clk) begin
    cyc++;
    ext_clk <= (cyc % 4) < 2;
    dma_ready <= (cyc % 3) != 0;
    if (arst_n && dma_valid && dma_ready) words.push_back(dma_data);
    if (arst_n && conv_start) begin
      gap = cyc - last;
      last = cyc;
    end
    n_done += arst_n && conv_done;
    n_start += arst_n && conv_start;
    n_tc += arst_n && term_count;
    if (cyc == 40000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string n);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(n, x, q)
  endtask
  task automatic wait_for(ref int c, input int n);
    for (int i = 0; i < 3000 && c < n; i++) @(posedge core_clk);
  endtask
  initial begin
    arst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    dig_trig = 0; ext_trig = 0; ext_clk = 0; dma_ready = 0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    rd(8'h00, {24'h0, acq_pkg::FUNC_RESET}, "func_reset");
    rd(8'h14, 32'h0000_0002, "status_reset");
    for (int i = 0; i < 10; i++) begin
      wr(8'h00, {24'h0, fv[i]});
      rd(8'h00, {24'h0, fv[i]}, "func");
      `CHK("burst_run", fv[i][4] & fv[i][3], burst_run)
      `CHK("burst_hold", fv[i][4] & fv[i][5], burst_hold)
    end
    wr(8'h00, 32'h0000_0000);
    apb(1'b0, 8'h20, 32'h0000_0000);
    `CHK("unmapped_err", 1'b1, e)
    `CHK("unmapped_data", 32'h0000_0000, q)
    $display("test registers done");
    for (int i = 0; i < 2; i++) begin
      b = n_done;
      wr(8'h04, i ? 32'h0000_0024 : 32'h0000_0004);
      t = 0;
      do begin apb(1'b0, 8'h14, 32'h0); t++; end while (q[1] !== 1'b0 && t < 50);
      `CHK("ready_n", 1'b0, q[1])
      rd(8'h18, i ? {20'h0, 12'hA50 + 12'(b)} : {16'h0, 12'hA50 + 12'(b), 4'h0},
         "result");
      apb(1'b0, 8'h14, 32'h0);
      `CHK("ready_n_clear", 1'b1, q[1])
    end
    $display("test polled done");
    b = n_done; t = n_tc;
    words.delete();
    wr(8'h08, 32'h0002_0001); wr(8'h0C, 32'd4); wr(8'h04, 32'h0000_0311);
    wait_for(n_tc, t + 1);
    repeat (10) @(posedge core_clk);
    `CHK("tc", t + 1, n_tc)
    `CHK("pace_gap", 50, gap)
    `CHK("words", 2, words.size())
    for (int k = 0; k < 2; k++) `CHK("dma_word", {12'hA50 + 12'(b + 2 * k + 1),
      4'(2 * k + 1), 12'hA50 + 12'(b + 2 * k), 4'(2 * k)}, words[k])
    apb(1'b0, 8'h14, 32'h0);
    `CHK("running", 1'b0, q[0])
    rd(8'h1C, 32'd4, "xfer_count");
    $display("test dma done");
    t = n_start;
    wr(8'h0C, 32'd100); wr(8'h04, 32'h0000_0009);
    wait_for(n_start, t + 3);
    `CHK("ext_gap", 8, gap)
    wr(8'h04, 32'h0000_0002);
    repeat (3) @(posedge core_clk);
    t = n_start; b = n_tc;
    repeat (300) @(posedge core_clk);
    `CHK("stopped", t, n_start)
    `CHK("stop_no_tc", b, n_tc)
    $display("test stop done");
    for (int i = 0; i < 2; i++) begin
      wr(8'h10, 32'd2); wr(8'h0C, 32'd1000); wr(8'h00, {24'h0, md[i]});
      t = n_tc;
      wr(8'h04, 32'h0000_0001);
      repeat (200) @(posedge core_clk);
      `CHK("armed_wait", t, n_tc)
      dig_trig <= 1'b1; ext_trig <= 1'b1;
      wait_for(n_tc, t + 1);
      `CHK("post_count_end", t + 1, n_tc)
      dig_trig <= 1'b0; ext_trig <= 1'b0;
      apb(1'b0, 8'h14, 32'h0);
      `CHK("trig_running", 1'b0, q[0])
    end
    $display("test trigger done");
    end_sim();
  end
endmodule
bind acq_ctrl acq_ctrl_assertions #(.CW(CW)) u_chk (.core_clk(core_clk), .arst_n(arst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .conv_start(conv_start), .conv_done(conv_done),
  .burst_run(burst_run), .burst_hold(burst_hold), .dma_valid(dma_valid),
  .dma_data(dma_data), .dma_ready(dma_ready), .term_count(term_count));
`default_nettype wire

// ==== test/conv_model.sv ====
// Behavioural converter answering each start with a tagged result
`timescale 1ns/1ps
`default_nettype none
module conv_model #(
  parameter int DLY = 5
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // Converter side of the block
  input  wire logic        conv_start,
  input  wire logic [3:0]  conv_chan,
  output logic             conv_done,
  output logic [15:0]      conv_value
);
  logic [7:0]  cnt;
  logic [11:0] seq;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt        <= 8'h00;
      seq        <= 12'hA50;
      conv_done  <= 1'b0;
      conv_value <= 16'h0000;
    end else begin
      conv_done  <= 1'b0;
      // Value only meaningful with done, so it toggles otherwise
      conv_value <= ~conv_value;
      if (conv_start) begin
        cnt  <= 8'(DLY);
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
      if (cnt == 8'h01) begin
        conv_done  <= 1'b1;
        // Raw right-aligned code; the block adds the channel field in narrow mode
        conv_value <= {4'h0, seq};
        seq        <= seq + 12'h001;
      end
    end
  end
endmodule
`default_nettype wire
